/* File: pkg/bem_pkg.sv */
package bem_pkg;
    localparam int NUM_CNT = 10;
    localparam int NUM_SLOT = 2;
    localparam int NUM_EXT = 2;
    localparam int CNT_W = 32;
    localparam int EV_W = 8;
    localparam int ID_W = 4;
    localparam int STRB_W = 4;
    localparam int OUT_W = 6;
    localparam int NUM_MET = 15;
    localparam int PROF_PER_SLOT = 6;
    localparam logic [CNT_W-1:0] CNT_RST = 32'h0;
    localparam logic [EV_W-1:0] BEAT_BYTES = 8'h04;
    localparam logic [OUT_W-1:0] OUT_MAX = 6'h20;

    // Metric codes selectable per counter
    typedef enum logic [3:0] {
        MET_WR_TXN = 4'h0,
        MET_RD_TXN = 4'h1,
        MET_RD_LAT = 4'h2,
        MET_WR_LAT = 4'h3,
        MET_WR_BYTE = 4'h4,
        MET_RD_BYTE = 4'h5,
        MET_WR_IDLE = 4'h6,
        MET_RD_IDLE = 4'h7,
        MET_ST_XFER = 4'h8,
        MET_ST_DATA = 4'h9,
        MET_ST_POS = 4'ha,
        MET_ST_NULL = 4'hb,
        MET_ST_PKT = 4'hc,
        MET_ST_IDLE = 4'hd,
        MET_EXT = 4'he
    } bem_met_t;

    // Memory-mapped slot probe
    typedef struct packed {
        logic awvalid;
        logic awready;
        logic [ID_W-1:0] awid;
        logic wvalid;
        logic wready;
        logic wlast;
        logic [STRB_W-1:0] wstrb;
        logic arvalid;
        logic arready;
        logic [ID_W-1:0] arid;
        logic rvalid;
        logic rready;
        logic rlast;
        logic [ID_W-1:0] rid;
    } bem_mm_t;

    // Stream slot probe
    typedef struct packed {
        logic tvalid;
        logic tready;
        logic tlast;
        logic [STRB_W-1:0] tkeep;
        logic [STRB_W-1:0] tstrb;
    } bem_st_t;

    // Filter and latency configuration
    typedef struct packed {
        logic filt_en;
        logic [ID_W-1:0] filt_id;
        logic [ID_W-1:0] filt_mask;
        logic rd_start_acc;
        logic rd_end_first;
        logic wr_start_acc;
        logic wr_end_first;
    } bem_cfg_t;

    // Per-counter metric selection
    typedef struct packed {
        logic src_slot;
        bem_met_t met;
    } bem_sel_t;

    function automatic logic [EV_W-1:0] bem_ones(input logic [STRB_W-1:0] v);
        logic [EV_W-1:0] n;
        n = '0;
        for (int k = 0; k < STRB_W; k++) begin
            n = n + {7'h0, v[k]};
        end
        return n;
    endfunction : bem_ones
endpackage : bem_pkg

/* File: verilog/bem_slot_events.sv */
`timescale 1ns/1ps
module bem_slot_events
    import bem_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input bem_mm_t mm,
    input bem_st_t st,
    input bem_cfg_t cfg,
    input wire logic filt_allow,
    output logic [NUM_MET-1:0][EV_W-1:0] ev
);
    logic aw_wait_r, ar_wait_r, w_pass_r, w_mid_r, r_mid_r;
    logic aw_wait_nxt, ar_wait_nxt, w_pass_nxt, w_mid_nxt, r_mid_nxt;
    logic [OUT_W-1:0] wr_out_r, rd_out_r, wr_out_nxt, rd_out_nxt;
    logic aw_hs, ar_hs, w_hs, r_hs, filt_on, aw_ok, ar_ok, r_ok;
    logic wr_start, wr_end, rd_start, rd_end;

    assign filt_on = cfg.filt_en & filt_allow;
    assign aw_ok = !filt_on || (((mm.awid ^ cfg.filt_id) & cfg.filt_mask) == '0);
    assign ar_ok = !filt_on || (((mm.arid ^ cfg.filt_id) & cfg.filt_mask) == '0);
    assign r_ok = !filt_on || (((mm.rid ^ cfg.filt_id) & cfg.filt_mask) == '0);
    assign aw_hs = mm.awvalid & mm.awready;
    assign ar_hs = mm.arvalid & mm.arready;
    assign w_hs = mm.wvalid & mm.wready & w_pass_r;
    assign r_hs = mm.rvalid & mm.rready & r_ok;

    // Latency window start and end points
    always_comb begin
        wr_start = aw_ok & (cfg.wr_start_acc ? aw_hs : (mm.awvalid & !aw_wait_r));
        wr_end = w_hs & (cfg.wr_end_first ? !w_mid_r : mm.wlast) & (wr_out_r != '0 || wr_start);
        rd_start = ar_ok & (cfg.rd_start_acc ? ar_hs : (mm.arvalid & !ar_wait_r));
        rd_end = r_hs & (cfg.rd_end_first ? !r_mid_r : mm.rlast) & (rd_out_r != '0 || rd_start);
        aw_wait_nxt = mm.awvalid & !mm.awready;
        ar_wait_nxt = mm.arvalid & !mm.arready;
        w_pass_nxt = aw_hs ? aw_ok : w_pass_r;
        w_mid_nxt = w_hs ? !mm.wlast : w_mid_r;
        r_mid_nxt = r_hs ? !mm.rlast : r_mid_r;
        wr_out_nxt = wr_out_r;
        if (wr_start && !wr_end && wr_out_r != OUT_MAX) wr_out_nxt = wr_out_r + 6'h01;
        if (wr_end && !wr_start) wr_out_nxt = wr_out_r - 6'h01;
        rd_out_nxt = rd_out_r;
        if (rd_start && !rd_end && rd_out_r != OUT_MAX) rd_out_nxt = rd_out_r + 6'h01;
        if (rd_end && !rd_start) rd_out_nxt = rd_out_r - 6'h01;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            aw_wait_r <= 1'b0;
            ar_wait_r <= 1'b0;
            w_pass_r <= 1'b1;
            w_mid_r <= 1'b0;
            r_mid_r <= 1'b0;
            wr_out_r <= '0;
            rd_out_r <= '0;
        end else begin
            aw_wait_r <= aw_wait_nxt;
            ar_wait_r <= ar_wait_nxt;
            w_pass_r <= w_pass_nxt;
            w_mid_r <= w_mid_nxt;
            r_mid_r <= r_mid_nxt;
            wr_out_r <= wr_out_nxt;
            rd_out_r <= rd_out_nxt;
        end
    end

    // Per-cycle increments for every metric except MET_EXT
    always_comb begin
        ev = '0;
        ev[MET_WR_TXN] = {7'h0, aw_hs & aw_ok};
        ev[MET_RD_TXN] = {7'h0, ar_hs & ar_ok};
        ev[MET_WR_BYTE] = w_hs ? bem_ones(mm.wstrb) : 8'h00;
        ev[MET_RD_BYTE] = r_hs ? BEAT_BYTES : 8'h00;
        ev[MET_WR_LAT] = {2'h0, wr_out_r};
        ev[MET_RD_LAT] = {2'h0, rd_out_r};
        ev[MET_WR_IDLE] = {7'h0, mm.wvalid & !mm.wready & w_pass_r};
        ev[MET_RD_IDLE] = {7'h0, mm.rvalid & !mm.rready & r_ok};
        ev[MET_ST_XFER] = {7'h0, st.tvalid & st.tready};
        if (st.tvalid && st.tready) begin
            ev[MET_ST_DATA] = bem_ones(st.tkeep & st.tstrb);
            ev[MET_ST_POS] = bem_ones(st.tkeep & ~st.tstrb);
            ev[MET_ST_NULL] = bem_ones(~st.tkeep);
        end
        ev[MET_ST_PKT] = {7'h0, st.tvalid & st.tready & st.tlast};
        ev[MET_ST_IDLE] = {7'h0, !st.tvalid};
    end
endmodule : bem_slot_events

/* File: verilog/bem_acc_range.sv */
`timescale 1ns/1ps
module bem_acc_range
    import bem_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clr,
    input wire logic en,
    input wire logic rng_en,
    input wire logic [EV_W-1:0] inc,
    input wire logic [CNT_W-1:0] lo,
    input wire logic [CNT_W-1:0] hi,
    output logic [CNT_W-1:0] acc_r,
    output logic [CNT_W-1:0] incr_r
);
    logic [CNT_W-1:0] acc_nxt, incr_nxt, val;

    // Accumulate and range-check each event value
    always_comb begin
        val = {24'h0, inc};
        acc_nxt = acc_r;
        incr_nxt = incr_r;
        if (clr) begin
            acc_nxt = CNT_RST;
            incr_nxt = CNT_RST;
        end else if (en) begin
            acc_nxt = acc_r + val;
            if (rng_en && inc != '0 && val >= lo && val <= hi) incr_nxt = incr_r + 32'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            acc_r <= CNT_RST;
            incr_r <= CNT_RST;
        end else begin
            acc_r <= acc_nxt;
            incr_r <= incr_nxt;
        end
    end
endmodule : bem_acc_range

/* File: verilog/bem_counters.sv */
`timescale 1ns/1ps
// Operation
// - Up to ten accumulator plus incrementer counters
// - Events filtered by ID value and mask
// - Filtering only while filter enable set
// - Selector picks metric and slot per counter
// - Per-counter count enable bit
// - Enabled triggers start counters, ignored for external
// - Incrementer counts values inside range limits
// - Accumulator and incrementer values readable
// - Capture input copies counters to samples
// - Reset event clears counters and samples
// - Interval timer expiry copies counters
// - Timer or read capture clears unless disabled
// - Sample read captures, returns free count
// - Profile free count starts at first read
// - External events counted between start, stop
// - Write, read, byte metrics for slots
// - Configurable read latency points
// - Configurable write latency points
// - Write idle: WVALID to WREADY
// - Read idle: RVALID to RREADY
// - Stream transfer, byte, packet, idle metrics
// - Profile uses fixed metrics, no extras
// - Profile triggers both start and stop
module bem_counters
    import bem_pkg::*;
#(
    parameter bit PROFILE = 1'b0
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input bem_mm_t [NUM_SLOT-1:0] mm_slot,
    input bem_st_t [NUM_SLOT-1:0] st_slot,
    input wire logic [NUM_SLOT-1:0] trig,
    input wire logic [NUM_EXT-1:0] ext_evt,
    input wire logic [NUM_EXT-1:0] ext_start,
    input wire logic [NUM_EXT-1:0] ext_stop,
    input wire logic ext_capture,
    input wire logic ext_reset,
    input bem_cfg_t cfg,
    input wire logic [NUM_CNT-1:0] cnt_en,
    input wire logic trig_en,
    input bem_sel_t [NUM_CNT-1:0] sel,
    input wire logic [NUM_CNT-1:0][CNT_W-1:0] rng_lo,
    input wire logic [NUM_CNT-1:0][CNT_W-1:0] rng_hi,
    input wire logic si_load,
    input wire logic [CNT_W-1:0] si_value,
    input wire logic si_run,
    input wire logic ard_dis,
    input wire logic smp_rd,
    output logic [CNT_W-1:0] smp_rd_data,
    output logic [NUM_CNT-1:0][CNT_W-1:0] acc,
    output logic [NUM_CNT-1:0][CNT_W-1:0] incr,
    output logic [NUM_CNT-1:0][CNT_W-1:0] smp_acc,
    output logic [NUM_CNT-1:0][CNT_W-1:0] smp_incr
);
    logic [NUM_SLOT-1:0][NUM_MET-1:0][EV_W-1:0] slot_ev;
    logic [NUM_SLOT-1:0] run_r, run_nxt;
    logic [NUM_EXT-1:0] ext_act_r, ext_act_nxt;
    logic [CNT_W-1:0] si_cnt_r, si_cnt_nxt;
    logic si_exp, si_armed_r, si_armed_nxt;
    logic [CNT_W-1:0] free_r, free_nxt;
    logic free_go_r, free_go_nxt;
    logic cap_any, clr_cnt, clr_smp;
    logic [NUM_CNT-1:0][CNT_W-1:0] smp_acc_nxt, smp_incr_nxt;

    // Event detection per monitored slot
    for (genvar s = 0; s < NUM_SLOT; s++) begin : g_slot
        bem_slot_events u_ev (
            .clk_sys(clk_sys),
            .rst(rst),
            .mm(mm_slot[s]),
            .st(st_slot[s]),
            .cfg(cfg),
            .filt_allow(!PROFILE),
            .ev(slot_ev[s])
        );
    end

    // Trigger run flags and external start/stop windows
    always_comb begin
        run_nxt = run_r;
        for (int s = 0; s < NUM_SLOT; s++) begin
            if (trig_en && trig[s]) begin
                run_nxt[s] = PROFILE ? !run_r[s] : 1'b1;
            end
        end
        ext_act_nxt = ext_act_r;
        for (int e = 0; e < NUM_EXT; e++) begin
            if (ext_stop[e]) ext_act_nxt[e] = 1'b0;
            if (ext_start[e]) ext_act_nxt[e] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            run_r <= '0;
            ext_act_r <= '0;
        end else begin
            run_r <= run_nxt;
            ext_act_r <= ext_act_nxt;
        end
    end

    // Sample interval timer
    always_comb begin
        si_cnt_nxt = si_cnt_r;
        si_armed_nxt = si_armed_r;
        si_exp = si_run && si_armed_r && si_cnt_r == CNT_RST;
        if (si_load) begin
            si_cnt_nxt = si_value;
            si_armed_nxt = 1'b1;
        end else if (si_exp) begin
            si_cnt_nxt = si_value;
        end else if (si_run && si_armed_r) begin
            si_cnt_nxt = si_cnt_r - 32'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            si_cnt_r <= CNT_RST;
            si_armed_r <= 1'b0;
        end else begin
            si_cnt_r <= si_cnt_nxt;
            si_armed_r <= si_armed_nxt;
        end
    end

    // Free-running count returned on sample reads
    always_comb begin
        free_go_nxt = free_go_r | smp_rd;
        free_nxt = free_r;
        if (free_go_r) free_nxt = free_r + 32'h1;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            free_r <= CNT_RST;
            free_go_r <= !PROFILE;
        end else begin
            free_r <= free_nxt;
            free_go_r <= free_go_nxt;
        end
    end

    assign smp_rd_data = free_r;

    // Capture and clear decisions
    always_comb begin
        cap_any = ext_capture | si_exp | smp_rd;
        clr_cnt = ext_reset | ((si_exp | smp_rd) & !ard_dis);
        clr_smp = ext_reset;
    end

    // Metric counters with selection and gating
    for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
        logic [EV_W-1:0] inc;
        logic gate, is_ext;
        logic [$clog2(NUM_SLOT)-1:0] sl;
        bem_met_t met;

        always_comb begin
            if (PROFILE) begin
                sl = 1'((i / PROF_PER_SLOT) % NUM_SLOT);
                unique case (i % PROF_PER_SLOT)
                    0: met = MET_WR_TXN;
                    1: met = MET_WR_BYTE;
                    2: met = MET_WR_LAT;
                    3: met = MET_RD_TXN;
                    4: met = MET_RD_BYTE;
                    default: met = MET_RD_LAT;
                endcase
            end else begin
                sl = sel[i].src_slot;
                met = sel[i].met;
            end
            is_ext = (met == MET_EXT);
            if (is_ext) begin
                inc = {7'h0, ext_evt[sl] & ext_act_r[sl]};
            end else begin
                inc = slot_ev[sl][met];
            end
            gate = cnt_en[i] & (!trig_en | is_ext | run_r[sl]);
        end

        bem_acc_range u_acc (
            .clk_sys(clk_sys),
            .rst(rst),
            .clr(clr_cnt),
            .en(gate),
            .rng_en(!PROFILE),
            .inc(inc),
            .lo(rng_lo[i]),
            .hi(rng_hi[i]),
            .acc_r(acc[i]),
            .incr_r(incr[i])
        );

        always_comb begin
            smp_acc_nxt[i] = smp_acc[i];
            smp_incr_nxt[i] = smp_incr[i];
            if (clr_smp) begin
                smp_acc_nxt[i] = CNT_RST;
                smp_incr_nxt[i] = CNT_RST;
            end else if (cap_any) begin
                smp_acc_nxt[i] = acc[i];
                smp_incr_nxt[i] = incr[i];
            end
        end

        always_ff @(posedge clk_sys) begin
            if (rst) begin
                smp_acc[i] <= CNT_RST;
                smp_incr[i] <= CNT_RST;
            end else begin
                smp_acc[i] <= smp_acc_nxt[i];
                smp_incr[i] <= smp_incr_nxt[i];
            end
        end
    end
endmodule : bem_counters

/* File: tb/bem_far_end.sv */
`timescale 1ns/1ps
module bem_far_end
    import bem_pkg::*;
(
    input wire logic clk_sys,
    output bem_mm_t mm,
    output bem_st_t st
);
    // Probed buses start idle
    initial begin
        mm = '0;
        st = '0;
    end
    // One cycle on, just after the edge
    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask : step
    task automatic wr(input logic [ID_W-1:0] id, input logic [STRB_W-1:0] strb, input int ws);
        step();
        mm.awvalid = 1'b1;
        mm.awready = 1'b1;
        mm.awid = id;
        mm.wvalid = 1'b1;
        mm.wlast = 1'b1;
        mm.wstrb = strb;
        mm.wready = (ws == 0);
        step();
        mm.awvalid = 1'b0;
        mm.awready = 1'b0;
        mm.awid = ~id;
        for (int k = 1; k <= ws; k++) begin
            mm.wready = (k == ws);
            step();
        end
        // Released qualifiers flip so stale values never match
        mm.wvalid = 1'b0;
        mm.wready = 1'b0;
        mm.wlast = 1'b0;
        mm.wstrb = ~strb;
    endtask : wr
    task automatic rd(input logic [ID_W-1:0] id, input int rs);
        step();
        mm.arvalid = 1'b1;
        mm.arready = 1'b1;
        mm.arid = id;
        step();
        mm.arvalid = 1'b0;
        mm.arready = 1'b0;
        mm.arid = ~id;
        mm.rvalid = 1'b1;
        mm.rlast = 1'b1;
        mm.rid = id;
        mm.rready = (rs == 0);
        for (int k = 1; k <= rs; k++) begin
            step();
            mm.rready = (k == rs);
        end
        step();
        mm.rvalid = 1'b0;
        mm.rready = 1'b0;
        mm.rlast = 1'b0;
        mm.rid = ~id;
    endtask : rd
    task automatic sb(input logic [STRB_W-1:0] keep, input logic [STRB_W-1:0] strb, input logic last);
        step();
        st.tvalid = 1'b1;
        st.tready = 1'b1;
        st.tkeep = keep;
        st.tstrb = strb;
        st.tlast = last;
        step();
        st.tvalid = 1'b0;
        st.tready = 1'b0;
        st.tkeep = ~keep;
        st.tstrb = ~strb;
        st.tlast = ~last;
    endtask : sb
endmodule : bem_far_end

/* File: tb/bem_counters_assertions.sv */
`timescale 1ns/1ps
module bem_counters_assertions
    import bem_pkg::*;
#(
    parameter bit PROFILE = 1'b0
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ext_capture,
    input wire logic ext_reset,
    input wire logic [NUM_CNT-1:0] cnt_en,
    input bem_sel_t [NUM_CNT-1:0] sel,
    input wire logic [NUM_CNT-1:0][CNT_W-1:0] rng_lo,
    input wire logic [NUM_CNT-1:0][CNT_W-1:0] rng_hi,
    input wire logic si_load,
    input wire logic [CNT_W-1:0] si_value,
    input wire logic si_run,
    input wire logic ard_dis,
    input wire logic smp_rd,
    input wire logic [CNT_W-1:0] smp_rd_data,
    input wire logic [NUM_CNT-1:0][CNT_W-1:0] acc,
    input wire logic [NUM_CNT-1:0][CNT_W-1:0] incr,
    input wire logic [NUM_CNT-1:0][CNT_W-1:0] smp_acc,
    input wire logic [NUM_CNT-1:0][CNT_W-1:0] smp_incr
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // No reset event, sample read or interval timer active
    logic quiet;
    assign quiet = !ext_reset && !smp_rd && !si_run;
    // Timer armed for five-cycle period, then left running
    sequence s_armed;
        si_load && si_value == 32'h4 && sel[9].met == MET_EXT;
    endsequence
    sequence s_running;
        si_run && !si_load && !ext_reset && !ard_dis && !smp_rd;
    endsequence
    a_capture_copy: assert property (
        ext_capture && !ext_reset |=> smp_acc == $past(acc) && smp_incr == $past(incr))
        else $error("capture did not copy counters");
    a_read_clears: assert property (
        smp_rd && !ard_dis && !ext_reset |=> acc == '0 && smp_acc == $past(acc))
        else $error("sample read did not capture and clear");
    a_read_keeps: assert property (
        smp_rd && ard_dis && !ext_reset && !si_run |=> smp_acc == $past(acc) && acc[0] >= $past(acc[0]))
        else $error("sample read cleared with auto clear off");
    a_evt_reset_clr: assert property (
        ext_reset |=> acc == '0 && smp_acc == '0)
        else $error("reset event left counters set");
    a_samples_hold: assert property (
        !ext_capture && quiet |=> $stable(smp_acc) && $stable(smp_incr))
        else $error("sampled counters moved without capture");
    a_disabled_hold: assert property (
        !cnt_en[0] && quiet |=> acc[0] == $past(acc[0]))
        else $error("disabled counter changed");
    a_free_step: assert property (
        !ext_reset && (!PROFILE || smp_rd_data != '0) |=> smp_rd_data == $past(smp_rd_data) + 32'h1)
        else $error("free count did not step by one");
    a_range_step: assert property (
        !PROFILE && cnt_en[0] && quiet |=> (incr[0] - $past(incr[0])) == {31'h0, (acc[0] != $past(acc[0]))
        && (acc[0] - $past(acc[0])) >= rng_lo[0] && (acc[0] - $past(acc[0])) <= rng_hi[0]})
        else $error("incrementer step disagrees with range");
    a_timer_bound: assert property (
        s_armed ##1 s_running [*8] |-> acc[9] <= 32'h5)
        else $error("interval timer did not capture and clear");
    a_prof_norange: assert property (
        PROFILE |-> incr == '0)
        else $error("profile incrementer moved");
endmodule : bem_counters_assertions

/* File: tb/bem_counters_test.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin \
    compares++; \
    if ((gt) !== (ex)) begin \
        fail_count++; \
        $display("ERROR %s expected %0h seen %0h", nm, ex, gt); \
    end \
end
module bem_counters_test
    import bem_pkg::*;
;
    typedef struct packed {
        bem_met_t met;
        logic [CNT_W-1:0] ea;
        logic [CNT_W-1:0] ei;
    } bem_row_t;
    // Metric per counter with expected sum and in-range count
    localparam bem_row_t ROWS [NUM_CNT] = '{
        '{MET_WR_TXN, 32'h1, 32'h1}, '{MET_RD_TXN, 32'h1, 32'h1}, '{MET_WR_BYTE, 32'h3, 32'h1},
        '{MET_RD_BYTE, 32'h4, 32'h0}, '{MET_WR_IDLE, 32'h2, 32'h2}, '{MET_RD_IDLE, 32'h1, 32'h1},
        '{MET_ST_DATA, 32'h5, 32'h2}, '{MET_ST_POS, 32'h2, 32'h1}, '{MET_ST_NULL, 32'h1, 32'h1},
        '{MET_ST_PKT, 32'h1, 32'h1}};
    logic clk_sys = 1'b0, rst = 1'b1;
    bem_mm_t fe_mm;
    bem_st_t fe_st;
    logic [NUM_SLOT-1:0] trig = '0;
    logic [NUM_EXT-1:0] ext_evt = '0, ext_start = '0, ext_stop = '0;
    logic ext_capture = 1'b0, ext_reset = 1'b0, trig_en = 1'b0;
    logic si_load = 1'b0, si_run = 1'b0, ard_dis = 1'b0, smp_rd = 1'b0;
    bem_cfg_t cfg = '0;
    bem_sel_t [NUM_CNT-1:0] sel = '0;
    logic [NUM_CNT-1:0] cnt_en = '0;
    logic [NUM_CNT-1:0][CNT_W-1:0] rng_lo = '0, rng_hi = '0, acc, incr, smp_acc, smp_incr, p_acc, p_incr;
    logic [CNT_W-1:0] si_value = '0, smp_rd_data, ts, p_rd_data;
    int fail_count = 0, compares = 0;
    bem_far_end u_bem_far_end (.clk_sys, .mm(fe_mm), .st(fe_st));
    bem_counters #(.PROFILE(1'b0)) u_bem_counters (.clk_sys, .rst, .mm_slot({bem_mm_t'('0), fe_mm}),
        .st_slot({bem_st_t'('0), fe_st}), .trig, .ext_evt, .ext_start, .ext_stop, .ext_capture,
        .ext_reset, .cfg, .cnt_en, .trig_en, .sel, .rng_lo, .rng_hi, .si_load, .si_value, .si_run,
        .ard_dis, .smp_rd, .smp_rd_data, .acc, .incr, .smp_acc, .smp_incr);
    // Profile copy sees the same stimulus
    bem_counters #(.PROFILE(1'b1)) u_bem_counters_prof (.clk_sys, .rst, .mm_slot({bem_mm_t'('0), fe_mm}),
        .st_slot({bem_st_t'('0), fe_st}), .trig, .ext_evt, .ext_start, .ext_stop, .ext_capture,
        .ext_reset, .cfg, .cnt_en, .trig_en, .sel, .rng_lo, .rng_hi, .si_load, .si_value, .si_run,
        .ard_dis, .smp_rd, .smp_rd_data(p_rd_data), .acc(p_acc), .incr(p_incr), .smp_acc(), .smp_incr());
    // Clock, 5 ns period
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step
    task automatic wrap_up();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up
    // Hang guard
    initial begin
        repeat (5000) @(posedge clk_sys);
        fail_count++;
        wrap_up();
    end
    // Main sequence
    initial begin
        step(12);
        rst = 1'b0;
        for (int i = 0; i < NUM_CNT; i++) begin
            sel[i].met = ROWS[i].met;
            rng_lo[i] = 32'h1;
            rng_hi[i] = 32'h3;
        end
        cnt_en = '1;
        cfg.filt_id = 4'h3;
        u_bem_far_end.wr(4'h5, 4'hb, 2);
        u_bem_far_end.rd(4'h3, 1);
        u_bem_far_end.sb(4'hf, 4'h3, 1'b0);
        u_bem_far_end.sb(4'h7, 4'h7, 1'b1);
        step(2);
        for (int i = 0; i < NUM_CNT; i++) begin
            `CHK("acc", ROWS[i].ea, acc[i])
            `CHK("incr", ROWS[i].ei, incr[i])
        end
        `CHK("p_map", 32'h3, p_acc[1])
        `CHK("p_rng", 32'h0, p_incr[1])
        ext_capture = 1'b1;
        step(1);
        ext_capture = 1'b0;
        `CHK("smp_acc", 32'h3, smp_acc[2])
        `CHK("smp_incr", 32'h2, smp_incr[4])
        `CHK("acc_kept", 32'h3, acc[2])
        ard_dis = 1'b1;
        smp_rd = 1'b1;
        ts = smp_rd_data;
        step(1);
        smp_rd = 1'b0;
        step(2);
        `CHK("acc_nodis", 32'h3, acc[2])
        ard_dis = 1'b0;
        smp_rd = 1'b1;
        `CHK("stamp", ts + 32'h3, smp_rd_data)
        `CHK("p_stamp", 32'h2, p_rd_data)
        step(1);
        smp_rd = 1'b0;
        `CHK("acc_clr", 32'h0, acc[2])
        `CHK("smp_read", 32'h3, smp_acc[2])
        ext_reset = 1'b1;
        step(1);
        ext_reset = 1'b0;
        `CHK("smp_clr", '0, smp_acc)
        sel[1].met = MET_WR_LAT;
        sel[2].met = MET_RD_LAT;
        sel[3].met = MET_ST_XFER;
        sel[4].met = MET_ST_IDLE;
        cnt_en[0] = 1'b0;
        // Address and last beat in one cycle add no latency
        u_bem_far_end.wr(4'h3, 4'h1, 0);
        u_bem_far_end.wr(4'h3, 4'h1, 2);
        u_bem_far_end.rd(4'h3, 1);
        u_bem_far_end.sb(4'hf, 4'hf, 1'b0);
        step(1);
        `CHK("wr_lat", 32'h2, acc[1])
        `CHK("rd_lat", 32'h2, acc[2])
        `CHK("st_xfer", 32'h1, acc[3])
        `CHK("st_idle", 32'hc, acc[4])
        cnt_en[0] = 1'b1;
        trig_en = 1'b1;
        u_bem_far_end.wr(4'h3, 4'h1, 0);
        step(1);
        `CHK("acc_off", 32'h0, acc[0])
        sel[9] = '{1'b0, MET_EXT};
        ext_start = 2'h1;
        step(1);
        ext_start = 2'h0;
        ext_evt = 2'h1;
        step(5);
        ext_evt = 2'h0;
        ext_stop = 2'h1;
        step(1);
        ext_stop = 2'h0;
        ext_evt = 2'h1;
        step(3);
        ext_evt = 2'h0;
        `CHK("ext", 32'h5, acc[9])
        `CHK("ext_incr", 32'h5, incr[9])
        trig = 2'h1;
        step(1);
        trig = 2'h0;
        u_bem_far_end.wr(4'h3, 4'h1, 0);
        step(1);
        `CHK("trig", 32'h1, acc[0])
        // A mismatching id is blocked under a full mask and passes under a zero mask
        cfg.filt_en = 1'b1;
        cfg.filt_mask = 4'hf;
        u_bem_far_end.wr(4'h3, 4'h1, 0);
        u_bem_far_end.wr(4'h5, 4'h1, 0);
        cfg.filt_mask = 4'h0;
        u_bem_far_end.wr(4'h5, 4'h1, 0);
        step(1);
        `CHK("filt", 32'h3, acc[0])
        `CHK("p_nofilt", 32'h4, p_acc[0])
        // Second pulse stops profile counting only
        trig = 2'h1;
        step(1);
        trig = 2'h0;
        u_bem_far_end.wr(4'h3, 4'h1, 0);
        step(1);
        `CHK("p_stop", 32'h4, p_acc[0])
        `CHK("trig_keep", 32'h4, acc[0])
        ext_start = 2'h1;
        ext_evt = 2'h1;
        si_value = 32'h4;
        si_load = 1'b1;
        si_run = 1'b1;
        step(1);
        ext_start = 2'h0;
        si_load = 1'b0;
        step(20);
        `CHK("timer", 32'h4, smp_acc[9])
        rst = 1'b1;
        step(2);
        `CHK("rst_stamp", 32'h0, smp_rd_data)
        rst = 1'b0;
        wrap_up();
    end
endmodule : bem_counters_test
bind bem_counters bem_counters_assertions #(.PROFILE(PROFILE)) u_bem_counters_assertions (.clk_sys, .rst, .ext_capture,
    .ext_reset, .cnt_en, .sel, .rng_lo, .rng_hi, .si_load, .si_value, .si_run, .ard_dis, .smp_rd,
    .smp_rd_data, .acc, .incr, .smp_acc, .smp_incr);
